// File: hdl/mpa_params.svh
// constants for the multichip phase alignment block
// assumes inclusion by bare name from the design, checker and bench files
`ifndef MPA_PARAMS_SVH
`define MPA_PARAMS_SVH
`define MPA_ADDR_OUT_DIS     8'h01
`define MPA_ADDR_PH_STAT     8'h0D
`define MPA_ADDR_ALIGN_CTRL  8'h10
`define MPA_ADDR_LOCK_STAT   8'h21
`define MPA_CTRL_MASTER      8'h70
`define MPA_CTRL_SLAVE       8'h50
`define MPA_BIT_OUT_DIS      5
`define MPA_BIT_PH90         5
`define MPA_BIT_PH0          4
`define MPA_BIT_TRK          7
`define MPA_BIT_LST          5
`define MPA_BIT_LCK          4
`define MPA_TAP_PS           12
`define MPA_FINE_TAPS        5'h10
`define MPA_FINE_MID         5'h08
`define MPA_FINE_MAX         5'h0F
`define MPA_ZERO8            8'h00
`define MPA_DIV_LAST         2'h3
`define MPA_DEL_W            6
`define MPA_DATA_PERIOD      6'h04
`endif

// File: hdl/mpa_pkg.sv
// state type of the device end of the phase alignment link; the host keeps its own
// assumes mpa_params.svh is present for constants
package mpa_pkg;
   typedef enum logic [2:0]
   {
      MPA_IDLE,
      MPA_COARSE,
      MPA_FINE,
      MPA_TRACK,
      MPA_SLV_ROT,
      MPA_SLV_LOCK
   } mpa_state_t;
endpackage : mpa_pkg

// File: hdl/mpa_link_if.sv
// link between a converter's alignment controller and its host
// assumes one clock shared by both parties
`timescale 1ns/1ps
interface mpa_link_if;
   logic       wr_en;     // host register write strobe
   logic       rd_en;     // host register read strobe
   logic [7:0] addr;      // register offset
   logic [7:0] wdata;     // write data
   logic [7:0] rdata;     // read data, valid cycle after rd_en
   logic       rvalid;    // read answer strobe
   logic [5:0] rx_delay;  // converged receiver delay readback
   logic       manual_rot;// host request to rotate data divider
   modport device (input wr_en, rd_en, addr, wdata, manual_rot,
                   output rdata, rvalid, rx_delay);
   modport host   (output wr_en, rd_en, addr, wdata, manual_rot,
                   input rdata, rvalid, rx_delay);
endinterface : mpa_link_if

// File: hdl/mpa_device.sv
// alignment controller of one converter: master or slave role
// assumes dac-rate phase bits sampled on mclk_i, ref input synchronous
// Notes on behaviour
// - control value 0x70 selects master role
// - master delays ref out to centre input
// - coarse by phase select, fine 12 ps taps
// - after centring, master keeps tracking drift
// - lock, lost and tracking bits at 0x21
// - control value 0x50 selects slave role
// - slave rotates divider until ref between phases
// - phase compare bits 5:4 at 0x0D
// - 0x01 bit 5 disables data clock only; ref out is not gated by it
// - adjacent divider phases one clock apart
// - receiver searches up and down from start
// - delays over one period mean four samples
// - host reprograms slave start to half difference
// - master ref output is clock over four
// - no manual rotation while controller enabled
`timescale 1ns/1ps
`include "mpa_params.svh"
module mpa_device
(
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rstn_i,
   // host side
   mpa_link_if.device      link,
   // reference path
   input  wire logic       ref_in_i,       // fed-back shared reference
   input  wire logic [5:0] rx_clk_edge_i,  // first valid edge position
   output logic            ref_out_o,      // reference output, fdac/4
   output logic            data_clock_output_o,
   output logic [1:0]      coarse_phase_selector_o,
   output logic [4:0]      fine_delay_o,   // taps of 12 ps each
   output logic [1:0]      div_phase_o,    // data-path divider phase
   output logic            pipe_mismatch_o // receiver lands 4 samples off
);
   mpa_pkg::mpa_state_t st_q, st_d;
   logic [7:0] ctrl_q, ctrl_d;        // alignment control register
   logic [7:0] odis_q, odis_d;        // output disable register
   logic [1:0] div_q, div_d;          // divide-by-4 counter
   logic [1:0] rot_q, rot_d;          // divider rotation offset
   logic [1:0] csel_q, csel_d;        // coarse phase selector
   logic [4:0] fine_q, fine_d;        // fine delay taps
   logic       lck_q, lck_d;
   logic       lst_q, lst_d;
   logic       trk_q, trk_d;
   logic       ph0_q, ph0_d;          // ref seen after 0 deg phase
   logic       ph90_q, ph90_d;        // ref seen after 90 deg phase
   logic       ref_q, ref_d;
   logic       dco_q, dco_d;
   logic [7:0] rdata_q, rdata_d;
   logic       rv_q, rv_d;
   logic [5:0] rxd_q, rxd_d;          // receiver delay found
   logic       mis_q, mis_d;
   logic [1:0] ph;                    // effective phase
   logic       is_master, is_slave, in_win;
   logic [5:0] diff;

   assign is_master = (ctrl_q == `MPA_CTRL_MASTER);
   assign is_slave  = (ctrl_q == `MPA_CTRL_SLAVE);
   // each count of div is one mclk, so adjacent phases one period apart
   assign ph = div_q + rot_q + csel_q;
   // ref sampled high between the 0 and 90 degree edges
   assign in_win = ph90_q & ~ph0_q;
   assign diff = (rx_clk_edge_i > rxd_q) ? rx_clk_edge_i - rxd_q
                                         : rxd_q - rx_clk_edge_i;

   // next-state: registers, divider, alignment machine, readback
   always_comb
   begin
      st_d = st_q; ctrl_d = ctrl_q; odis_d = odis_q;
      div_d = div_q + 2'h1; rot_d = rot_q; csel_d = csel_q;
      fine_d = fine_q; lck_d = lck_q; lst_d = lst_q; trk_d = trk_q;
      rdata_d = `MPA_ZERO8; rv_d = 1'b0; rxd_d = rxd_q; mis_d = mis_q;
      // phase comparators sample ref against 0 and 90 degree phases
      ph0_d  = (ph == 2'h0) ? ref_in_i : ph0_q;
      ph90_d = (ph == 2'h1) ? ref_in_i : ph90_q;
      ref_d  = is_master ? ~ph[1] : 1'b0;
      dco_d  = odis_q[`MPA_BIT_OUT_DIS] ? 1'b0 : ~div_q[1];
      if (link.wr_en)
      begin
         if (link.addr == `MPA_ADDR_OUT_DIS)
            odis_d = link.wdata;
         else if (link.addr == `MPA_ADDR_ALIGN_CTRL)
         begin
            ctrl_d = link.wdata;
            st_d = mpa_pkg::MPA_IDLE;
         end
      end
      if (link.rd_en)
      begin
         rv_d = 1'b1;
         if (link.addr == `MPA_ADDR_OUT_DIS)
            rdata_d = odis_q;
         else if (link.addr == `MPA_ADDR_PH_STAT)
         begin
            rdata_d[`MPA_BIT_PH90] = ph90_q;
            rdata_d[`MPA_BIT_PH0]  = ph0_q;
         end
         else if (link.addr == `MPA_ADDR_ALIGN_CTRL)
            rdata_d = ctrl_q;
         else if (link.addr == `MPA_ADDR_LOCK_STAT)
         begin
            rdata_d[`MPA_BIT_TRK] = trk_q;
            rdata_d[`MPA_BIT_LST] = lst_q;
            rdata_d[`MPA_BIT_LCK] = lck_q;
         end
      end
      // manual rotation only when controller idle
      if (link.manual_rot && !is_master && !is_slave)
         rot_d = rot_q + 2'h1;
      // receiver search: step up or down toward first valid edge
      if (rxd_q < rx_clk_edge_i)
         rxd_d = rxd_q + 6'h01;
      else if (rxd_q > rx_clk_edge_i)
         rxd_d = rxd_q - 6'h01;
      mis_d = (diff > `MPA_DATA_PERIOD);
      // alignment machine runs once per divider cycle
      if (div_q == `MPA_DIV_LAST)
      begin
         case (st_q)
            mpa_pkg::MPA_IDLE:
            begin
               lck_d = 1'b0; trk_d = 1'b0;
               fine_d = `MPA_FINE_MID;
               if (is_master)
                  st_d = mpa_pkg::MPA_COARSE;
               else if (is_slave)
                  st_d = mpa_pkg::MPA_SLV_ROT;
            end
            mpa_pkg::MPA_COARSE:
            begin
               // shift ref out by whole phases until window hit
               if (in_win)
                  st_d = mpa_pkg::MPA_FINE;
               else
                  csel_d = csel_q + 2'h1;
            end
            mpa_pkg::MPA_FINE:
            begin
               // no fine stepping here: window still hit at mid tap means centred, lock and track
               if (!in_win)
                  st_d = mpa_pkg::MPA_COARSE;
               else
               begin
                  lck_d = 1'b1;
                  trk_d = 1'b1;
                  st_d = mpa_pkg::MPA_TRACK;
               end
            end
            mpa_pkg::MPA_TRACK:
            begin
               // nudge fine taps to hold centre against drift
               if (!in_win)
               begin
                  lck_d = 1'b0;
                  lst_d = 1'b1;
                  if (ph0_q && fine_q != `MPA_FINE_MAX)
                     fine_d = fine_q + 5'h01;
                  else if (!ph90_q && fine_q != 5'h00)
                     fine_d = fine_q - 5'h01;
               end
               else
                  lck_d = 1'b1;
            end
            mpa_pkg::MPA_SLV_ROT:
            begin
               if (in_win)
               begin
                  lck_d = 1'b1;
                  st_d = mpa_pkg::MPA_SLV_LOCK;
               end
               else
                  rot_d = rot_q + 2'h1;
            end
            mpa_pkg::MPA_SLV_LOCK:
            begin
               if (!in_win)
               begin
                  lck_d = 1'b0;
                  lst_d = 1'b1;
                  st_d = mpa_pkg::MPA_SLV_ROT;
               end
            end
            default:
               st_d = mpa_pkg::MPA_IDLE;
         endcase
         if (!is_master && !is_slave)
            st_d = mpa_pkg::MPA_IDLE;
      end
   end

   // register all state
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         st_q <= mpa_pkg::MPA_IDLE; ctrl_q <= `MPA_ZERO8;
         odis_q <= `MPA_ZERO8; div_q <= 2'h0; rot_q <= 2'h0;
         csel_q <= 2'h0; fine_q <= `MPA_FINE_MID; lck_q <= 1'b0;
         lst_q <= 1'b0; trk_q <= 1'b0; ph0_q <= 1'b0; ph90_q <= 1'b0;
         ref_q <= 1'b0; dco_q <= 1'b0; rdata_q <= `MPA_ZERO8;
         rv_q <= 1'b0; rxd_q <= 6'h00; mis_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d; ctrl_q <= ctrl_d; odis_q <= odis_d;
         div_q <= div_d; rot_q <= rot_d; csel_q <= csel_d;
         fine_q <= fine_d; lck_q <= lck_d; lst_q <= lst_d;
         trk_q <= trk_d; ph0_q <= ph0_d; ph90_q <= ph90_d;
         ref_q <= ref_d; dco_q <= dco_d; rdata_q <= rdata_d;
         rv_q <= rv_d; rxd_q <= rxd_d; mis_q <= mis_d;
      end
   end

   assign link.rdata = rdata_q;
   assign link.rvalid = rv_q;
   assign link.rx_delay = rxd_q;
   assign ref_out_o = ref_q;
   assign data_clock_output_o = dco_q;
   assign coarse_phase_selector_o = csel_q;
   assign fine_delay_o = fine_q;
   assign div_phase_o = rot_q;
   assign pipe_mismatch_o = mis_q;
endmodule : mpa_device

// File: hdl/mpa_host.sv
// host end: writes role, polls status, corrects receiver start
// assumes device answers reads one cycle after rd_en
`timescale 1ns/1ps
`include "mpa_params.svh"
module mpa_host
(
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rstn_i,
   // device side
   mpa_link_if.host        link,
   // user side
   input  wire logic       start_i,       // begin alignment sequence
   input  wire logic       master_i,      // role to program
   input  wire logic [5:0] master_delay_i,// master readback delay
   output logic            aligned_o,     // phase bits confirmed
   output logic [5:0]      slave_start_o, // new slave start delay
   output logic            reprog_o       // slave start should change
);
   typedef enum logic [2:0]
   {
      MPH_IDLE, MPH_WR, MPH_RD, MPH_WAIT, MPH_DONE
   } mpa_hst_state_t;
   mpa_hst_state_t st_q, st_d;
   logic [7:0] wd_q, wd_d, ad_q, ad_d;
   logic       we_q, we_d, re_q, re_d;
   logic       al_q, al_d, rp_q, rp_d;
   logic [5:0] ss_q, ss_d, dif;

   assign dif = (master_delay_i > link.rx_delay)
              ? master_delay_i - link.rx_delay
              : link.rx_delay - master_delay_i;

   // host sequencer next state
   always_comb
   begin
      st_d = st_q; wd_d = wd_q; ad_d = ad_q; we_d = 1'b0; re_d = 1'b0;
      al_d = al_q; rp_d = rp_q; ss_d = ss_q;
      case (st_q)
         MPH_IDLE:
            if (start_i)
            begin
               ad_d = `MPA_ADDR_ALIGN_CTRL;
               wd_d = master_i ? `MPA_CTRL_MASTER : `MPA_CTRL_SLAVE;
               we_d = 1'b1;
               al_d = 1'b0;
               st_d = MPH_WR;
            end
         MPH_WR:
         begin
            ad_d = `MPA_ADDR_PH_STAT;
            re_d = 1'b1;
            st_d = MPH_RD;
         end
         MPH_RD:
            st_d = MPH_WAIT;
         MPH_WAIT:
            if (link.rvalid)
            begin
               // aligned when 90 bit is 1 and 0 bit is 0
               if (link.rdata[`MPA_BIT_PH90] && !link.rdata[`MPA_BIT_PH0])
               begin
                  al_d = 1'b1;
                  st_d = MPH_DONE;
               end
               else
                  st_d = MPH_WR;
            end
         MPH_DONE:
         begin
            // delays more than one data period apart: restart at half
            rp_d = (dif > `MPA_DATA_PERIOD);
            // new start is half the gap between the two readbacks
            ss_d = dif >> 1;
            st_d = MPH_IDLE;
         end
         default:
            st_d = MPH_IDLE;
      endcase
   end

   // register host state
   always_ff @(posedge mclk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         st_q <= MPH_IDLE; wd_q <= `MPA_ZERO8; ad_q <= `MPA_ZERO8;
         we_q <= 1'b0; re_q <= 1'b0; al_q <= 1'b0; rp_q <= 1'b0;
         ss_q <= 6'h00;
      end
      else
      begin
         st_q <= st_d; wd_q <= wd_d; ad_q <= ad_d; we_q <= we_d;
         re_q <= re_d; al_q <= al_d; rp_q <= rp_d; ss_q <= ss_d;
      end
   end

   assign link.wr_en = we_q;
   assign link.rd_en = re_q;
   assign link.addr = ad_q;
   assign link.wdata = wd_q;
   assign link.manual_rot = 1'b0;
   assign aligned_o = al_q;
   assign slave_start_o = ss_q;
   assign reprog_o = rp_q;
endmodule : mpa_host

// File: dv/mpa_link_assertions.sv
// checker for the register link between host and device ends
// assumes one clock; instantiated beside the link in the bench top
`timescale 1ns/1ps
`include "mpa_params.svh"
module mpa_link_assertions
(
   // clock and reset
   input wire logic       mclk_i,
   input wire logic       rstn_i,
   // link signals
   input wire logic       wr_en,
   input wire logic       rd_en,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic       rvalid,
   input wire logic [5:0] rx_delay,
   input wire logic       manual_rot
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rstn_i);

   // read of one offset taken at an edge
   sequence s_rd(a);
      rd_en && addr == a;
   endsequence

   // read of an offset that holds no register
   sequence s_rd_unmapped;
      rd_en && addr != `MPA_ADDR_OUT_DIS && addr != `MPA_ADDR_PH_STAT
         && addr != `MPA_ADDR_ALIGN_CTRL && addr != `MPA_ADDR_LOCK_STAT;
   endsequence

   a_read_answer: assert property (rd_en |=> rvalid)
      else $error("read not answered next cycle");
   a_valid_cause: assert property (rvalid |-> $past(rd_en))
      else $error("answer strobe without a read");
   a_idle_data_zero: assert property (!rvalid |-> rdata == 8'h00)
      else $error("read data not zero outside answer");
   a_lock_reserved: assert property (s_rd(`MPA_ADDR_LOCK_STAT)
      |=> rdata[6] == 1'b0 && rdata[3:0] == 4'h0)
      else $error("unused status bits set");
   a_unmapped_zero: assert property (s_rd_unmapped |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_delay_step: assert property (rx_delay == $past(rx_delay)
      || rx_delay == $past(rx_delay) + 6'h01
      || rx_delay == $past(rx_delay) - 6'h01)
      else $error("receiver delay jumped");
   a_manual_no_read: assert property (manual_rot && !rd_en |=> !rvalid)
      else $error("rotation request raised a read answer");
   a_track_locked: assert property (s_rd(`MPA_ADDR_LOCK_STAT) ##1 rdata[7]
      |-> rdata[4])
      else $error("tracking without lock");
endmodule : mpa_link_assertions

// File: dv/multichip_phase_align_tb.sv
// bench: master pair through its host, slave device driven by tasks
// assumes reads answer one cycle after rd_en, inputs change at negedge
`timescale 1ns/1ps
`include "mpa_params.svh"
module multichip_phase_align_tb;
   logic        mclk_i = 1'b0; // 20 mhz clock
   logic        rstn_i = 1'b0; // async reset, low active
   logic        start_i = 1'b0;  // host sequence start
   logic [5:0]  mdel = 6'h0A;    // master delay seen by host
   logic        ref_a, dco_a, ref_b, dco_b, aligned, reprog;
   logic [5:0]  sstart;          // slave start proposed by host
   logic [1:0]  phase_b;         // slave divider phase
   logic [7:0]  rd;              // last read value
   logic [1:0]  ph_hold;         // phase before manual request
   logic [31:0] tg;              // toggle counts, 8 bits each
   int          err_count, n_tests;
   wire  [3:0]  outs = {ref_a, dco_a, ref_b, dco_b};

   always #25 mclk_i = ~mclk_i;

   mpa_link_if link_a ();
   mpa_link_if link_b ();
   mpa_device mpa_device_i (.mclk_i(mclk_i), .rstn_i(rstn_i), .link(link_a),
      .ref_in_i(ref_a), .rx_clk_edge_i(6'h14), .ref_out_o(ref_a),
      .data_clock_output_o(dco_a), .coarse_phase_selector_o(),
      .fine_delay_o(), .div_phase_o(), .pipe_mismatch_o());
   mpa_host mpa_host_i (.mclk_i(mclk_i), .rstn_i(rstn_i), .link(link_a),
      .start_i(start_i), .master_i(1'b1), .master_delay_i(mdel),
      .aligned_o(aligned), .slave_start_o(sstart), .reprog_o(reprog));
   mpa_device mpa_device_b_i (.mclk_i(mclk_i), .rstn_i(rstn_i),
      .link(link_b), .ref_in_i(ref_a), .rx_clk_edge_i(6'h0A),
      .ref_out_o(ref_b), .data_clock_output_o(dco_b),
      .coarse_phase_selector_o(), .fine_delay_o(), .div_phase_o(phase_b),
      .pipe_mismatch_o());
   mpa_link_assertions mpa_link_assertions_i (.mclk_i(mclk_i),
      .rstn_i(rstn_i), .wr_en(link_b.wr_en), .rd_en(link_b.rd_en),
      .addr(link_b.addr), .wdata(link_b.wdata), .rdata(link_b.rdata),
      .rvalid(link_b.rvalid), .rx_delay(link_b.rx_delay),
      .manual_rot(link_b.manual_rot));

   // report verdict and stop
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test

   // compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // register write on the slave link
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      link_b.wr_en = 1'b1;
      link_b.addr = a;
      link_b.wdata = d;
      @(negedge mclk_i);
      link_b.wr_en = 1'b0;
   endtask : wr

   // register read; answer stands in the cycle after the request
   task automatic rdr(input logic [7:0] a);
      @(negedge mclk_i);
      link_b.rd_en = 1'b1;
      link_b.addr = a;
      @(negedge mclk_i);
      link_b.rd_en = 1'b0;
      rd = link_b.rdata;
      chk({7'h00, link_b.rvalid}, 8'h01);
   endtask : rdr

   // count toggles of each watched output over 16 cycles
   task automatic toggles;
      logic [3:0] prev;
      tg = 32'h0000_0000;
      prev = outs;
      repeat (16)
      begin
         @(negedge mclk_i);
         for (int k = 0; k < 4; k++)
            if (outs[k] !== prev[k])
               tg[8*k +: 8] = tg[8*k +: 8] + 8'h01;
         prev = outs;
      end
   endtask : toggles

   // watchdog: far beyond the expected run length
   initial
   begin
      #(50 * 20000);
      err_count++;
      finish_test();
   end

   // main sequence
   initial
   begin
      link_b.wr_en = 1'b0;
      link_b.rd_en = 1'b0;
      link_b.addr = 8'h00;
      link_b.wdata = 8'h00;
      link_b.manual_rot = 1'b0;
      repeat (3) @(negedge mclk_i);
      rstn_i = 1'b1;
      // master pair: host programs, device centres and tracks
      // let the receiver delay settle before the host compares it
      repeat (24) @(negedge mclk_i);
      start_i = 1'b1;
      @(negedge mclk_i);
      start_i = 1'b0;
      for (int i = 0; i < 2000 && aligned !== 1'b1; i++) @(negedge mclk_i);
      chk({7'h00, aligned}, 8'h01);
      repeat (60) @(negedge mclk_i);
      chk({7'h00, reprog}, 8'h01);
      chk({2'h0, sstart}, 8'h05);
      toggles();
      chk(tg[31:24], 8'h08);
      chk(tg[23:16], 8'h08);
      $display("test master done");
      // idle controller lets the divider be rotated by hand
      link_b.manual_rot = 1'b1;
      @(negedge mclk_i);
      link_b.manual_rot = 1'b0;
      chk({6'h00, phase_b}, 8'h01);
      // slave rotates until reference sits between phases
      wr(`MPA_ADDR_ALIGN_CTRL, `MPA_CTRL_SLAVE);
      rd = 8'h00;
      for (int i = 0; i < 200 && rd[5:4] !== 2'b10; i++)
         rdr(`MPA_ADDR_PH_STAT);
      chk({6'h00, rd[5:4]}, 8'h02);
      chk({6'h00, phase_b}, 8'h00);
      rdr(`MPA_ADDR_ALIGN_CTRL);
      chk(rd, `MPA_CTRL_SLAVE);
      rdr(`MPA_ADDR_LOCK_STAT);
      chk(rd & 8'hB0, 8'h10);
      $display("test slave done");
      // manual rotation refused while enabled
      ph_hold = phase_b;
      link_b.manual_rot = 1'b1;
      repeat (8) @(negedge mclk_i);
      chk({6'h00, phase_b}, {6'h00, ph_hold});
      link_b.manual_rot = 1'b0;
      $display("test rotation done");
      // output disable bit silences data clock; slave reference stays low throughout
      toggles();
      chk(tg[7:0], 8'h08);
      chk(tg[15:8], 8'h00);
      wr(`MPA_ADDR_OUT_DIS, 8'h20);
      // one edge for the last enabled clock level to clear
      @(negedge mclk_i);
      toggles();
      chk(tg[7:0], 8'h00);
      chk(tg[15:8], 8'h00);
      rdr(`MPA_ADDR_OUT_DIS);
      chk(rd, 8'h20);
      $display("test disable done");
      // unmapped offset: write ignored, read gives zero
      wr(8'h33, 8'hFF);
      rdr(8'h33);
      chk(rd, 8'h00);
      rdr(`MPA_ADDR_ALIGN_CTRL);
      chk(rd, `MPA_CTRL_SLAVE);
      $display("test unmapped done");
      finish_test();
   end
endmodule : multichip_phase_align_tb
